// ---- psi_defs.svh ----
// Constants of the serial PCM input block: timing, framing, register map.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef PSI_DEFS_SVH
`define PSI_DEFS_SVH

`define PSI_CLK_PERIOD_NS    40
`define PSI_NOCLK_NS         4000
`define PSI_NOCLK_CYC        ((`PSI_NOCLK_NS) / (`PSI_CLK_PERIOD_NS))
`define PSI_INIT_NS          20000
`define PSI_INIT_CYC         (((`PSI_INIT_NS) + (`PSI_CLK_PERIOD_NS) - 1) / (`PSI_CLK_PERIOD_NS))

`define PSI_FMT_RJ16         3'h0
`define PSI_FMT_RJ20         3'h1
`define PSI_FMT_RJ24         3'h2
`define PSI_FMT_I2S16        3'h3
`define PSI_FMT_I2S20        3'h4
`define PSI_FMT_I2S24        3'h5
`define PSI_FMT_LJ16         3'h6
`define PSI_FMT_DSP16        3'h7

`define PSI_LAST_SLOT_HALF   6'h1f
`define PSI_LAST_SLOT_FRAME  6'h3f
`define PSI_DSP_LATCH_SLOT   6'h20

`define PSI_PWM_MID          8'h80
`define PSI_PWM_MIN          8'h81

`define PSI_REG_CTRL         8'h00
`define PSI_REG_STATUS       8'h04
`define PSI_REG_LEFT         8'h08
`define PSI_REG_RIGHT        8'h0c
`define PSI_CTRL_SOFT_MUTE   0
`define PSI_CTRL_REINIT      1
`define PSI_STAT_VALID       0
`define PSI_STAT_NOCLK       1
`define PSI_STAT_FMT_LSB     4
`define PSI_STAT_STATE_LSB   8
`define PSI_STAT_QMUTE       12
`define PSI_RESP_OKAY        2'b00
`define PSI_RESP_SLVERR      2'b10

`endif

// ---- psi_pkg.sv ----
// Types shared by the serial PCM input block and its PWM stage.
// Holds no logic.
package psi_pkg;

  typedef enum logic [2:0] {
    PSI_ST_INIT = 3'b001,
    PSI_ST_RUN  = 3'b010,
    PSI_ST_ERR  = 3'b100
  } psi_state_e;

  typedef enum logic [2:0] {
    PSI_PWM_HARD  = 3'b001,
    PSI_PWM_QUIET = 3'b010,
    PSI_PWM_AUDIO = 3'b100
  } psi_pwm_e;

endpackage

// ---- psi_pwm_chan.sv ----
// One stereo channel of the PWM output stage: two differential legs.
// Assumes mode and level come from logic on the same clock.
`timescale 1ns/10ps
`include "psi_defs.svh"

module psi_pwm_chan (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire psi_pkg::psi_pwm_e mode,
  input  wire logic [7:0]       level,
  output logic                  a_pos,
  output logic                  a_neg,
  output logic                  b_pos,
  output logic                  b_neg
);

  logic [7:0] cnt_q;
  logic [7:0] duty_a_q;
  logic [7:0] duty_b_q;
  logic [7:0] lvl;
  logic       a_on;
  logic       b_on;

  // Most negative code clamped so the B leg never wraps to full off
  assign lvl = (level == `PSI_PWM_MID) ? `PSI_PWM_MIN : level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Duty reloaded only at wrap, so no pulse is cut short mid-period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_a_q <= `PSI_PWM_MID;
      duty_b_q <= `PSI_PWM_MID;
    end else if (cnt_q == 8'hff) begin
      duty_a_q <= `PSI_PWM_MID + lvl;
      duty_b_q <= `PSI_PWM_MID - lvl;
    end
  end

  assign a_on = (mode == psi_pkg::PSI_PWM_QUIET) ? (cnt_q < `PSI_PWM_MID) : (cnt_q < duty_a_q);
  assign b_on = (mode == psi_pkg::PSI_PWM_QUIET) ? (cnt_q < `PSI_PWM_MID) : (cnt_q < duty_b_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_pos <= 1'b0;
      a_neg <= 1'b1;
      b_pos <= 1'b0;
      b_neg <= 1'b1;
    end else begin
      case (mode)
        psi_pkg::PSI_PWM_QUIET, psi_pkg::PSI_PWM_AUDIO: begin
          a_pos <= a_on;
          a_neg <= ~a_on;
          b_pos <= b_on;
          b_neg <= ~b_on;
        end
        default: begin
          a_pos <= 1'b0;
          a_neg <= 1'b1;
          b_pos <= 1'b0;
          b_neg <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ---- psi_serial_in.sv ----
// Serial PCM audio input with clock error status and PWM output control.
// Assumes bit clock, word clock, data and pins are asynchronous to aclk.
// How it works
// - Clock loss or phase error drops both valid outputs low.
// - While a clock error lasts, all PWM pairs are hard-muted.
// - When the error clears, initialisation reruns, then valid goes high.
// - Three select pins form format number 0 to 7, bit2 most significant.
// - Modes 0, 1, 2 are right-justified 16, 20, 24 bit, MSB first.
// - Modes 3, 4, 5 are I2S-style 16, 20, 24 bit.
// - Mode 6 is 16-bit left-justified; mode 7 is 16-bit DSP frame.
// - Each word clock period spans exactly 64 bit clocks.
// - Justified formats: left while word clock high, right while low.
// - I2S-style: left while word clock low, right while high.
// - Justified and I2S formats capture data on rising bit clock.
// - DSP format captures data on falling bit clock.
// - Hard mute holds positive outputs low and negative outputs high.
// - Quiet mute drives both sides at 50 percent duty.
// - Normal operation outputs differential PWM of the received audio.
// - Any format pin change during operation restarts initialisation.
// - Mute input low gives quiet mute; high gives audio.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "psi_defs.svh"

module psi_serial_in (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        bit_clk,
  input  wire logic        chan_clk,
  input  wire logic        serial_audio_in,
  input  wire logic        format_sel_bit0,
  input  wire logic        format_sel_bit1,
  input  wire logic        format_sel_bit2,
  input  wire logic        mute_n,
  output logic             left_valid_out,
  output logic             right_valid_out,
  output logic             left_a_positive_out,
  output logic             left_a_negative_out,
  output logic             left_b_positive_out,
  output logic             left_b_negative_out,
  output logic             right_a_positive_out,
  output logic             right_a_negative_out,
  output logic             right_b_positive_out,
  output logic             right_b_negative_out,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [23:0] psi_extract(input logic [2:0] m, input logic [31:0] s);
    case (m)
      `PSI_FMT_RJ16:  return {s[15:0], 8'h00};
      `PSI_FMT_RJ20:  return {s[19:0], 4'h0};
      `PSI_FMT_RJ24:  return s[23:0];
      `PSI_FMT_I2S16: return {s[30:15], 8'h00};
      `PSI_FMT_I2S20: return {s[30:11], 4'h0};
      `PSI_FMT_I2S24: return s[30:7];
      `PSI_FMT_LJ16:  return {s[31:16], 8'h00};
      default:        return {s[15:0], 8'h00};
    endcase
  endfunction

  function automatic logic psi_addr_ok(input logic [7:0] a);
    return (a == `PSI_REG_CTRL) || (a == `PSI_REG_STATUS) ||
           (a == `PSI_REG_LEFT) || (a == `PSI_REG_RIGHT);
  endfunction

  logic [6:0]          sync1_q;
  logic [6:0]          sync2_q;
  logic                bclk_d1_q;
  logic                bclk_s;
  logic                wclk_s;
  logic                din_s;
  logic                mute_n_s;
  logic [2:0]          fmt_s;
  logic [2:0]          fmt_last_q;
  logic                fmt_chg;
  logic                is_dsp;
  logic                is_i2s;
  logic                bclk_rise;
  logic                bclk_fall;
  logic                cap;
  logic                frame;
  logic [5:0]          last_slot;
  logic                ph_err;
  logic                good_frame;
  logic                clk_err;
  logic [31:0]         shreg_q;
  logic [5:0]          cnt_q;
  logic                wclk_last_q;
  logic                synced_q;
  logic [23:0]         ext_val;
  logic [23:0]         left_q;
  logic [23:0]         right_q;
  logic [7:0]          wd_q;
  logic                no_clk_q;
  psi_pkg::psi_state_e st_q;
  logic [15:0]         init_cnt_q;
  psi_pkg::psi_pwm_e   pmode;
  logic                soft_mute_q;
  logic                reinit_q;
  logic                aw_hold_q;
  logic                w_hold_q;
  logic [7:0]          awaddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                wr_go;
  logic [31:0]         rd_val;

  // Two-stage synchronisers; stage one is read only by stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q   <= 7'h00;
      sync2_q   <= 7'h00;
      bclk_d1_q <= 1'b0;
    end else begin
      sync1_q   <= {mute_n, format_sel_bit2, format_sel_bit1, format_sel_bit0,
                    serial_audio_in, chan_clk, bit_clk};
      sync2_q   <= sync1_q;
      bclk_d1_q <= sync2_q[0];
    end
  end

  assign bclk_s   = sync2_q[0];
  assign wclk_s   = sync2_q[1];
  assign din_s    = sync2_q[2];
  assign fmt_s    = sync2_q[5:3];
  assign mute_n_s = sync2_q[6];

  assign is_dsp    = (fmt_s == `PSI_FMT_DSP16);
  assign is_i2s    = (fmt_s >= `PSI_FMT_I2S16) && (fmt_s <= `PSI_FMT_I2S24);
  assign bclk_rise = bclk_s & ~bclk_d1_q;
  assign bclk_fall = ~bclk_s & bclk_d1_q;
  assign cap       = is_dsp ? bclk_fall : bclk_rise;
  // DSP framing keys on the sync pulse rising; others on either edge
  assign frame     = is_dsp ? (wclk_s & ~wclk_last_q) : (wclk_s ^ wclk_last_q);
  assign last_slot = is_dsp ? `PSI_LAST_SLOT_FRAME : `PSI_LAST_SLOT_HALF;
  // Early or missing word clock edge both break the 64-slot frame
  assign ph_err     = cap & synced_q & (frame ? (cnt_q != last_slot)
                                              : (cnt_q == last_slot));
  assign good_frame = cap & frame & synced_q & (cnt_q == last_slot);
  assign clk_err    = no_clk_q | ph_err;
  assign ext_val    = psi_extract(fmt_s, shreg_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_last_q <= 3'h0;
    end else begin
      fmt_last_q <= fmt_s;
    end
  end
  assign fmt_chg = (fmt_s != fmt_last_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q     <= 32'h0000_0000;
      cnt_q       <= 6'h00;
      wclk_last_q <= 1'b0;
    end else if (cap) begin
      shreg_q     <= {shreg_q[30:0], din_s};
      wclk_last_q <= wclk_s;
      cnt_q       <= frame ? 6'h00 : cnt_q + 6'h01;
    end
  end

  // First edge after a disturbance only aligns; it is not checked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synced_q <= 1'b0;
    end else if (no_clk_q || ph_err || fmt_chg) begin
      synced_q <= 1'b0;
    end else if (cap && frame) begin
      synced_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q  <= 24'h00_0000;
      right_q <= 24'h00_0000;
    end else if (good_frame && !is_dsp) begin
      // Finished half belongs to the level the word clock just left
      if (is_i2s ^ wclk_last_q) begin
        left_q  <= ext_val;
      end else begin
        right_q <= ext_val;
      end
    end else if (cap && synced_q && is_dsp && !frame && cnt_q == `PSI_DSP_LATCH_SLOT) begin
      left_q  <= psi_extract(`PSI_FMT_LJ16, shreg_q);
      right_q <= psi_extract(`PSI_FMT_RJ16, shreg_q);
    end
  end

  // Bit clock watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_q     <= 8'h00;
      no_clk_q <= 1'b0;
    end else if (bclk_rise || bclk_fall) begin
      wd_q     <= 8'h00;
      no_clk_q <= 1'b0;
    end else if (wd_q != 8'(`PSI_NOCLK_CYC - 1)) begin
      wd_q     <= wd_q + 8'h01;
    end else begin
      no_clk_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= psi_pkg::PSI_ST_INIT;
      init_cnt_q <= 16'h0000;
    end else begin
      case (st_q)
        psi_pkg::PSI_ST_INIT: begin
          if (clk_err) begin
            st_q <= psi_pkg::PSI_ST_ERR;
          end else if (fmt_chg || reinit_q) begin
            init_cnt_q <= 16'h0000;
          end else if (init_cnt_q == 16'(`PSI_INIT_CYC - 1)) begin
            st_q <= psi_pkg::PSI_ST_RUN;
          end else begin
            init_cnt_q <= init_cnt_q + 16'h0001;
          end
        end
        psi_pkg::PSI_ST_RUN: begin
          if (clk_err) begin
            st_q <= psi_pkg::PSI_ST_ERR;
          end else if (fmt_chg || reinit_q) begin
            st_q       <= psi_pkg::PSI_ST_INIT;
            init_cnt_q <= 16'h0000;
          end
        end
        psi_pkg::PSI_ST_ERR: begin
          if (good_frame && !no_clk_q) begin
            st_q       <= psi_pkg::PSI_ST_INIT;
            init_cnt_q <= 16'h0000;
          end
        end
        default: begin
          st_q       <= psi_pkg::PSI_ST_INIT;
          init_cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  assign left_valid_out  = (st_q == psi_pkg::PSI_ST_RUN);
  assign right_valid_out = (st_q == psi_pkg::PSI_ST_RUN);
  assign pmode = (st_q != psi_pkg::PSI_ST_RUN) ? psi_pkg::PSI_PWM_HARD :
                 (!mute_n_s || soft_mute_q)    ? psi_pkg::PSI_PWM_QUIET :
                                                 psi_pkg::PSI_PWM_AUDIO;

  psi_pwm_chan u_pwm_left (
    .aclk    (aclk),
    .aresetn (aresetn),
    .mode    (pmode),
    .level   (left_q[23:16]),
    .a_pos   (left_a_positive_out),
    .a_neg   (left_a_negative_out),
    .b_pos   (left_b_positive_out),
    .b_neg   (left_b_negative_out)
  );

  psi_pwm_chan u_pwm_right (
    .aclk    (aclk),
    .aresetn (aresetn),
    .mode    (pmode),
    .level   (right_q[23:16]),
    .a_pos   (right_a_positive_out),
    .a_neg   (right_a_negative_out),
    .b_pos   (right_b_positive_out),
    .b_neg   (right_b_negative_out)
  );

  // AXI4-Lite slave: address and data accepted in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_hold_q && w_hold_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PSI_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= psi_addr_ok(awaddr_q) ? `PSI_RESP_OKAY : `PSI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Reinit bit is a one-cycle request; it never reads back as set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_mute_q <= 1'b0;
      reinit_q    <= 1'b0;
    end else if (wr_go && awaddr_q == `PSI_REG_CTRL && wstrb_q[0]) begin
      soft_mute_q <= wdata_q[`PSI_CTRL_SOFT_MUTE];
      reinit_q    <= wdata_q[`PSI_CTRL_REINIT];
    end else begin
      reinit_q    <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      `PSI_REG_CTRL: begin
        rd_val[`PSI_CTRL_SOFT_MUTE] = soft_mute_q;
      end
      `PSI_REG_STATUS: begin
        rd_val[`PSI_STAT_VALID]          = left_valid_out;
        rd_val[`PSI_STAT_NOCLK]          = no_clk_q;
        rd_val[`PSI_STAT_FMT_LSB +: 3]   = fmt_s;
        rd_val[`PSI_STAT_STATE_LSB +: 3] = st_q;
        rd_val[`PSI_STAT_QMUTE]          = (pmode == psi_pkg::PSI_PWM_QUIET);
      end
      `PSI_REG_LEFT:  rd_val = {8'h00, left_q};
      `PSI_REG_RIGHT: rd_val = {8'h00, right_q};
      default:        rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PSI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= psi_addr_ok(s_axi_araddr) ? `PSI_RESP_OKAY : `PSI_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_err_valid;
    clk_err |=> !left_valid_out && !right_valid_out;
  endproperty
  a_err_valid: assert property (p_err_valid) else $error("valid high after clock error");

  property p_hard_mute;
    (st_q != psi_pkg::PSI_ST_RUN) |=> !left_a_positive_out && left_a_negative_out &&
      !left_b_positive_out && left_b_negative_out && !right_a_positive_out &&
      right_a_negative_out && !right_b_positive_out && right_b_negative_out;
  endproperty
  a_hard_mute: assert property (p_hard_mute) else $error("outputs not hard-muted");

  property p_init_len;
    $rose(left_valid_out) |-> $past(init_cnt_q) == 16'(`PSI_INIT_CYC - 1);
  endproperty
  a_init_len: assert property (p_init_len) else $error("valid rose before init end");

  property p_err_exit;
    (st_q == psi_pkg::PSI_ST_ERR) ##1 (st_q != psi_pkg::PSI_ST_ERR)
      |-> st_q == psi_pkg::PSI_ST_INIT && !left_valid_out;
  endproperty
  a_err_exit: assert property (p_err_exit) else $error("error left without init");

  property p_fmt_restart;
    (st_q == psi_pkg::PSI_ST_RUN && fmt_chg && !clk_err) |=> st_q == psi_pkg::PSI_ST_INIT;
  endproperty
  a_fmt_restart: assert property (p_fmt_restart) else $error("format change ignored");

  property p_cap_edge;
    cap |-> (is_dsp ? (!bclk_s && bclk_d1_q) : (bclk_s && !bclk_d1_q));
  endproperty
  a_cap_edge: assert property (p_cap_edge) else $error("capture on wrong edge");

  property p_frame_len;
    ph_err |=> st_q == psi_pkg::PSI_ST_ERR ##1 st_q == psi_pkg::PSI_ST_ERR;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad frame not flagged");

  property p_chan_left;
    (good_frame && !is_dsp && (is_i2s ^ wclk_last_q)) |=> left_q == $past(ext_val);
  endproperty
  a_chan_left: assert property (p_chan_left) else $error("left sample not taken");

  property p_rj16;
    (good_frame && fmt_s == `PSI_FMT_RJ16 && !wclk_last_q) |=> right_q[23:8] == $past(shreg_q[15:0]);
  endproperty
  a_rj16: assert property (p_rj16) else $error("right-justified slice wrong");

  property p_quiet;
    (pmode == psi_pkg::PSI_PWM_QUIET) |=> left_a_positive_out == left_b_positive_out &&
      right_a_positive_out == right_b_positive_out && left_a_negative_out != left_a_positive_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("quiet mute not symmetric");

  property p_audio_diff;
    (pmode == psi_pkg::PSI_PWM_AUDIO) |=> left_a_negative_out == !left_a_positive_out &&
      right_b_negative_out == !right_b_positive_out;
  endproperty
  a_audio_diff: assert property (p_audio_diff) else $error("audio outputs not differential");

  c_valid_rise: cover property ($rose(left_valid_out));
  c_quiet:      cover property (pmode == psi_pkg::PSI_PWM_QUIET);
  c_dsp_frame:  cover property (good_frame && is_dsp);
  c_err_state:  cover property (st_q == psi_pkg::PSI_ST_ERR);

endmodule

// ---- psi_pcm_src.sv ----
// Serial PCM source model for the eight framing modes.
// Assumes the bench sets run, mode and samples; mode is taken per frame.
`timescale 1ns/10ps

module psi_pcm_src (
  input  wire logic        run,
  input  wire logic [2:0]  mode,
  input  wire logic [23:0] left,
  input  wire logic [23:0] right,
  output logic             bit_clk,
  output logic             chan_clk,
  output logic             serial_audio_in
);
  logic [2:0] m;
  int         w;

  function automatic logic slot_bit(input logic [2:0] md, input int wd, input int s,
                                    input logic [23:0] l, input logic [23:0] r);
    int          k;
    logic [23:0] d;
    k = s % 32;
    d = (s < 32) ? l : r;
    if (md == 3'h7) begin
      d = (s < 17) ? l : r;
      k = (s < 17) ? s - 1 : s - 17;
      return (s >= 1 && s <= 32) ? d[23 - k] : 1'b0;
    end
    if (md < 3'h3)
      k = k - (32 - wd);
    else if (md < 3'h6)
      k = k - 1;
    return (k >= 0 && k < wd) ? d[23 - k] : 1'b0;
  endfunction

  initial begin
    bit_clk = 1'b0;
    chan_clk = 1'b0;
    serial_audio_in = 1'b0;
    forever begin
      if (!run) begin
        bit_clk = 1'b0;  // Clock stands still while run is low
        #320;
      end else begin
        m = mode;
        w = (m < 3'h6) ? 16 + 4 * (m % 3) : 16;
        for (int i = 0; i < 64; i++) begin
          bit_clk = (m == 3'h7);
          chan_clk = (m == 3'h7) ? (i == 0) : ((m > 3'h2 && m < 3'h6) ^ (i < 32));
          serial_audio_in = slot_bit(m, w, i, left, right);
          #160 bit_clk = (m != 3'h7);
          #160;
        end
      end
    end
  end
endmodule

// ---- psi_serial_in_tb_top.sv ----
// Bench for the serial PCM input: formats, clock loss, mute, registers.
// Assumes psi_pcm_src drives the serial pins; every check is made here.
`timescale 1ns/10ps
`include "psi_defs.svh"

module psi_serial_in_tb_top;
  localparam logic [23:0] L_SMP = 24'h9abcde;
  localparam logic [23:0] R_SMP = 24'h3579b1;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        run     = 1'b1;
  logic        mute_n  = 1'b1;
  logic [2:0]  fmt     = 3'h0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        bit_clk, chan_clk, sdata, lv, rv, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  pwm;
  logic [31:0] rdata;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0;
  int          compares = 0;

  psi_pcm_src SRC (.run(run), .mode(fmt), .left(L_SMP), .right(R_SMP), .bit_clk(bit_clk),
                   .chan_clk(chan_clk), .serial_audio_in(sdata));

  psi_serial_in DUT (.aclk(aclk), .aresetn(aresetn), .bit_clk(bit_clk), .chan_clk(chan_clk),
    .serial_audio_in(sdata), .format_sel_bit0(fmt[0]), .format_sel_bit1(fmt[1]),
    .format_sel_bit2(fmt[2]), .mute_n(mute_n), .left_valid_out(lv), .right_valid_out(rv),
    .left_a_positive_out(pwm[7]), .left_b_positive_out(pwm[6]),
    .right_a_positive_out(pwm[5]), .right_b_positive_out(pwm[4]),
    .left_a_negative_out(pwm[3]), .left_b_negative_out(pwm[2]),
    .right_a_negative_out(pwm[1]), .right_b_negative_out(pwm[0]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wait_valid;
    for (int i = 0; i < 4000 && lv !== 1'b1; i++)
      @(posedge aclk);
    chk("valid pins", 32'h3, {30'h0, lv, rv});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    // Ready stays high: a back-to-back call would otherwise drive it twice in one step
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic duty(input int b, input int exp);
    int c;
    c = 0;
    repeat (256) begin
      @(posedge aclk);
      if (pwm[b] === 1'b1)
        c++;
    end
    chk("pwm high count", exp, c);
  endtask

  task automatic t_format(input logic [2:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    int          w;
    w = (m < 3'h6) ? 16 + 4 * (m % 3) : 16;
    if (m != 3'h0) begin
      fmt <= m;
      cyc(20);
      chk("valid after format change", 32'h0, {30'h0, lv, rv});
    end
    wait_valid();
    cyc(1100);
    rd(`PSI_REG_LEFT, d, r);
    chk("left", {8'h00, L_SMP & (24'hffffff << (24 - w))}, d);
    rd(`PSI_REG_RIGHT, d, r);
    chk("right", {8'h00, R_SMP & (24'hffffff << (24 - w))}, d);
  endtask

  task automatic t_pwm;
    duty(7, 26);
    duty(6, 230);
    mute_n <= 1'b0;
    cyc(600);
    duty(7, 128);
    duty(3, 128);
    mute_n <= 1'b1;
  endtask

  task automatic t_clock_loss;
    run <= 1'b0;
    // Source ends its frame first (up to 512 cycles), then the watchdog needs 100
    cyc(700);
    chk("valid without clocks", 32'h0, {30'h0, lv, rv});
    chk("hard mute pins", 32'h0f, {24'h0, pwm});
    run <= 1'b1;
    wait_valid();
  endtask

  task automatic t_axi;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`PSI_REG_STATUS, d, r);
    chk("status format", 32'h7, {29'h0, d[6:4]});
    rd(8'h40, d, r);
    chk("unmapped read resp", {30'h0, `PSI_RESP_SLVERR}, {30'h0, r});
    wr(8'h40, 32'h3, r);
    chk("unmapped write resp", {30'h0, `PSI_RESP_SLVERR}, {30'h0, r});
    wr(`PSI_REG_CTRL, 32'h1, r);
    chk("ctrl write resp", {30'h0, `PSI_RESP_OKAY}, {30'h0, r});
    rd(`PSI_REG_STATUS, d, r);
    chk("soft mute status", 32'h1, {31'h0, d[`PSI_STAT_QMUTE]});
    duty(7, 128);
    wr(`PSI_REG_CTRL, 32'h2, r);
    rd(`PSI_REG_STATUS, d, r);
    chk("valid after reinit", 32'h0, {31'h0, d[`PSI_STAT_VALID]});
    wait_valid();
    duty(7, 26);
  endtask

  initial begin
    #2400000;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("valid at reset", 32'h0, {30'h0, lv, rv});
    chk("pwm at reset", 32'h0f, {24'h0, pwm});
    for (int m = 0; m < 8; m++)
      t_format(3'(m));
    t_pwm();
    t_clock_loss();
    t_axi();
    end_of_test();
  end
endmodule
